// ==== rtl/mpl_party_filter.sv ====
// Party-line address filter with Avalon-MM control registers
`timescale 1ns/10ps
`default_nettype none

// Contract
// - On a shared multidrop line the party enable flag is set to one; zero, the reset value, disables it.
// - A party command opens with the unit name and closes with a CTRL+J, which ends the command.
// - After reset or after party mode is enabled, party mode turns active only after one CTRL+J.
// - The unit name resets to the exclamation mark until software changes it.
// - Commands prefixed by the asterisk are accepted whatever the unit name is.
// - Any active hardware address input forces party mode on.
// - The queued flag may be written at any time but affects addressing only in party mode.
// - A queued unit accepts commands that carry the caret group address.
// - A unit that is not queued ignores commands that carry the caret group address; the code still accepts them when its unit name is the caret.
// - The queued flag holds zero or one and resets to zero.
// - A line longer than 64 characters yields a CR/LF and error 20.
module mpl_party_filter
  import mpl_pkg::*;
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  // Avalon-MM slave
  input  wire logic [3:0]           avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [3:0]           avs_byteenable_i,
  input  wire logic [31:0]          avs_writedata_i,
  output logic [31:0]               avs_readdata_o,
  output logic                      avs_waitrequest_o,
  // Line side
  input  wire mpl_char_type         rx_i,
  input  wire logic [HW_ADDR_W-1:0] hw_addr_i,
  output mpl_cmd_type               cmd_o,
  output mpl_err_type               err_o,
  output logic                      crlf_o,
  output logic                      party_active_o
);

  function automatic logic is_term(input logic       party,
                                   input logic [7:0] ch);
    // Party lines end on CTRL+J, a direct line on Enter
    is_term = party ? (ch == CHAR_LF) : (ch == CHAR_CR);
  endfunction

  logic          party_en_r;
  logic          queued_r;
  logic [7:0]    unit_name_r;
  logic          active_r;
  mpl_state_type state_r;
  mpl_state_type state_nxt;
  logic [6:0]    cnt_r;
  mpl_cmd_type   cmd_r;
  mpl_cmd_type   cmd_nxt;
  mpl_err_type   err_r;
  logic          crlf_r;
  logic          ack_r;
  logic [31:0]   rdata_r;

  logic          req;
  logic          wr_take;
  logic          hw_forced;
  logic          eff_party;
  logic          term;
  logic          overflow;
  logic          hit;
  logic [31:0]   rd_word;

  // Bus slave: one wait cycle, answer on the second edge

  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_r;
  assign wr_take           = avs_write_i & ack_r;
  assign avs_readdata_o    = rdata_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'h0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (avs_address_i[3:2])
      OFS_CTRL: begin
        rd_word[CTRL_PARTY_BIT] = party_en_r;
        rd_word[CTRL_QUEUE_BIT] = queued_r;
      end
      OFS_NAME: begin
        rd_word[7:0] = unit_name_r;
      end
      OFS_STATUS: begin
        rd_word[STAT_EFF_BIT]  = eff_party;
        rd_word[STAT_ACT_BIT]  = active_r;
        rd_word[STAT_HW_BIT]   = hw_forced;
        rd_word[STAT_BUSY_BIT] = (state_r != ST_IDLE);
        rd_word[STAT_QEFF_BIT] = eff_party & queued_r;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Read data captured in the wait cycle, held for the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_r <= 32'h0000_0000;
    end else if (avs_read_i & ~ack_r) begin
      rdata_r <= rd_word;
    end
  end

  // Control register; only byte lane 0 carries fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      party_en_r <= PARTY_RESET;
      queued_r   <= QUEUE_RESET;
    end else if (wr_take && avs_byteenable_i[0]
                 && avs_address_i[3:2] == OFS_CTRL) begin
      party_en_r <= avs_writedata_i[CTRL_PARTY_BIT];
      // Writable outside party mode too
      queued_r   <= avs_writedata_i[CTRL_QUEUE_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      unit_name_r <= NAME_RESET;
    end else if (wr_take && avs_byteenable_i[0]
                 && avs_address_i[3:2] == OFS_NAME) begin
      unit_name_r <= avs_writedata_i[7:0];
    end
  end

  // Line side

  assign hw_forced = |hw_addr_i;
  assign eff_party = party_en_r | hw_forced;
  assign term      = is_term(eff_party, rx_i.data);
  assign overflow  = rx_i.valid & ~term
                     & (cnt_r == LINE_MAX);

  mpl_addr_match u_match (
    .char_i      (rx_i.data),
    .unit_name_i (unit_name_r),
    .queued_i    (queued_r),
    .party_i     (eff_party),
    .hit_o       (hit)
  );

  // Activation: cleared whenever party mode is off, so re-enabling
  // needs a fresh CTRL+J
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_r <= 1'h0;
    end else if (!eff_party) begin
      active_r <= 1'h0;
    end else if (rx_i.valid && term) begin
      active_r <= 1'h1;
    end
  end

  // Characters per line, terminator excluded
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= 7'h00;
    end else if (rx_i.valid) begin
      if (term) begin
        cnt_r <= 7'h00;
      end else if (cnt_r != LINE_MAX) begin
        cnt_r <= cnt_r + 7'h01;
      end
    end
  end

  always_comb begin
    state_nxt = state_r;
    cmd_nxt   = '0;
    cmd_nxt.data = rx_i.data;
    if (!rx_i.valid) begin
      state_nxt = state_r;
    end else if (eff_party && !active_r) begin
      // Nothing passes until the first CTRL+J
      state_nxt = ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (term) begin
            state_nxt = ST_IDLE;
          end else if (!eff_party) begin
            state_nxt     = ST_PASS;
            cmd_nxt.valid = 1'h1;
          end else if (hit) begin
            // Prefix is consumed, not forwarded
            state_nxt = ST_PASS;
          end else begin
            state_nxt = ST_DROP;
          end
        end
        ST_PASS: begin
          if (term) begin
            state_nxt     = ST_IDLE;
            cmd_nxt.valid = 1'h1;
            cmd_nxt.last  = 1'h1;
          end else if (overflow) begin
            // Interpreter drops what it has so far
            state_nxt     = ST_DROP;
            cmd_nxt.valid = 1'h1;
            cmd_nxt.last  = 1'h1;
            cmd_nxt.abort = 1'h1;
          end else begin
            cmd_nxt.valid = 1'h1;
          end
        end
        ST_DROP: begin
          if (term) begin
            state_nxt = ST_IDLE;
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_r <= '0;
    end else begin
      cmd_r <= cmd_nxt;
    end
  end

  // Error reported for every char past the limit, also for discarded lines
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      err_r  <= '0;
      crlf_r <= 1'h0;
    end else begin
      err_r.valid <= overflow;
      err_r.code  <= overflow ? ERR_LINE_LONG : 8'h00;
      crlf_r      <= overflow;
    end
  end

  assign cmd_o          = cmd_r;
  assign err_o          = err_r;
  assign crlf_o         = crlf_r;
  assign party_active_o = active_r;

  // Checks

  chk_bus_answer: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (req && avs_waitrequest_o) |=> (!avs_waitrequest_o || !req))
    else $error("bus answer later than one wait cycle");

  chk_reset_values: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> (!queued_r && !party_en_r
                      && unit_name_r == NAME_RESET))
    else $error("control reset values wrong");

  chk_inactive_drop: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (eff_party && !active_r) |=> !cmd_r.valid)
    else $error("command passed before activation");

  chk_lf_activates: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rx_i.valid && rx_i.data == CHAR_LF && eff_party && !active_r)
    |=> active_r)
    else $error("CTRL+J did not activate party mode");

  chk_hw_forces: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (hw_forced && !party_en_r && !active_r && rx_i.valid
     && rx_i.data == CHAR_LF) |=> active_r)
    else $error("address inputs did not force party mode");

  chk_global_pass: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (active_r && eff_party && state_r == ST_IDLE && rx_i.valid
     && rx_i.data == CHAR_GLOBAL) |=> state_r == ST_PASS)
    else $error("global name not accepted");

  chk_group_queued: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (active_r && eff_party && queued_r && state_r == ST_IDLE
     && rx_i.valid && rx_i.data == CHAR_GROUP) |=> state_r == ST_PASS)
    else $error("queued unit ignored group address");

  chk_group_unqueued: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (active_r && eff_party && !queued_r && unit_name_r != CHAR_GROUP
     && state_r == ST_IDLE && rx_i.valid && rx_i.data == CHAR_GROUP)
    |=> (state_r == ST_DROP ##1 !cmd_r.valid))
    else $error("unqueued unit took group address");

  chk_foreign_silent: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_r == ST_DROP && eff_party) |=> !cmd_r.valid)
    else $error("foreign command forwarded");

  chk_term_ends: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_r == ST_PASS && eff_party && active_r && rx_i.valid
     && rx_i.data == CHAR_LF) |=> (cmd_r.valid && cmd_r.last
                                    && !cmd_r.abort && state_r == ST_IDLE))
    else $error("CTRL+J did not end the command");

  chk_long_line: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rx_i.valid && !term && cnt_r == LINE_MAX)
    |=> (err_r.valid && err_r.code == ERR_LINE_LONG && crlf_r))
    else $error("long line not reported");

  chk_abort_long: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_r == ST_PASS && overflow && (!eff_party || active_r))
    |=> (cmd_r.valid && cmd_r.last && cmd_r.abort && state_r == ST_DROP))
    else $error("forwarded long line not aborted");

  chk_off_clears: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !eff_party |=> !active_r)
    else $error("activation kept with party mode off");

  chk_own_name: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (active_r && eff_party && state_r == ST_IDLE && rx_i.valid
     && !term && rx_i.data == unit_name_r) |=> state_r == ST_PASS)
    else $error("own unit name not accepted");

endmodule

`default_nettype wire

// ==== rtl/mpl_pkg.sv ====
// Constants and carrier types of the party-line address filter
package mpl_pkg;

  // Characters on the line
  localparam logic [7:0] CHAR_LF        = 8'h0A;
  localparam logic [7:0] CHAR_CR        = 8'h0D;
  localparam logic [7:0] CHAR_GLOBAL    = 8'h2A;
  localparam logic [7:0] CHAR_GROUP     = 8'h5E;
  localparam logic [7:0] NAME_RESET     = 8'h21;

  // Receive line limit and its error
  localparam logic [6:0] LINE_MAX       = 7'h40;
  localparam logic [7:0] ERR_LINE_LONG  = 8'h14;

  // Hardware address inputs
  localparam int         HW_ADDR_W      = 4;

  // Register word offsets (byte address bits 3:2)
  localparam logic [1:0] OFS_CTRL       = 2'h0;
  localparam logic [1:0] OFS_NAME       = 2'h1;
  localparam logic [1:0] OFS_STATUS     = 2'h2;

  // Control fields
  localparam int         CTRL_PARTY_BIT = 0;
  localparam int         CTRL_QUEUE_BIT = 1;
  localparam logic       PARTY_RESET    = 1'h0;
  localparam logic       QUEUE_RESET    = 1'h0;

  // Status fields
  localparam int         STAT_EFF_BIT   = 0;
  localparam int         STAT_ACT_BIT   = 1;
  localparam int         STAT_HW_BIT    = 2;
  localparam int         STAT_BUSY_BIT  = 3;
  localparam int         STAT_QEFF_BIT  = 4;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } mpl_char_type;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic       abort;
    logic [7:0] data;
  } mpl_cmd_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } mpl_err_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_PASS,
    ST_DROP
  } mpl_state_type;

endpackage

// ==== rtl/mpl_addr_match.sv ====
// Prefix comparator for one command line
`timescale 1ns/10ps
`default_nettype none

module mpl_addr_match
  import mpl_pkg::*;
(
  input  wire logic [7:0] char_i,
  input  wire logic [7:0] unit_name_i,
  input  wire logic       queued_i,
  input  wire logic       party_i,
  output logic            hit_o
);

  logic own_hit;
  logic global_hit;
  logic group_hit;

  assign own_hit    = (char_i == unit_name_i);
  assign global_hit = (char_i == CHAR_GLOBAL);
  // Queued only counts on a party line
  assign group_hit  = party_i & queued_i
                      & (char_i == CHAR_GROUP);
  // Group caret matches a non-queued unit only when the caret is its own unit name
  assign hit_o      = party_i
                      & (own_hit | global_hit | group_hit);

endmodule

`default_nettype wire

// ==== sim/mpl_host_model.sv ====
// Behavioural host that sends command lines on the shared serial line
`timescale 1ns/10ps
`default_nettype none

module mpl_host_model
  import mpl_pkg::*;
(
  input  wire logic       clk_i,
  output var mpl_char_type rx_o
);
  initial rx_o = '0;

  // Idle data is the inverse of the last char, so stale data never matches
  task automatic send_str(input string s, input int gap);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge clk_i);
      rx_o <= '{valid: 1'b1, data: s[i]};
      repeat (gap) begin
        @(posedge clk_i);
        rx_o <= '{valid: 1'b0, data: ~s[i]};
      end
    end
    @(posedge clk_i);
    rx_o <= '{valid: 1'b0, data: ~s[s.len()-1]};
    // Quiet time so the unit can finish a line before the next one
    repeat (4) @(posedge clk_i);
  endtask
endmodule

`default_nettype wire

// ==== sim/multidrop_party_line_addressing_test.sv ====
// Self-checking bench for the party-line address filter
`timescale 1ns/10ps
`default_nettype none

module multidrop_party_line_addressing_test
  import mpl_pkg::*;
;
  logic                 clk_i;
  logic                 rst_i;
  logic [3:0]           avs_address_i;
  logic                 avs_read_i;
  logic                 avs_write_i;
  logic [3:0]           avs_byteenable_i;
  logic [31:0]          avs_writedata_i;
  logic [31:0]          avs_readdata_o;
  logic                 avs_waitrequest_o;
  mpl_char_type         rx;
  logic [HW_ADDR_W-1:0] hw_addr_i;
  mpl_cmd_type          cmd_o;
  mpl_err_type          err_o;
  logic                 crlf_o;
  logic                 party_active_o;
  logic [8:0]           got_q[$];
  int                   err_seen;
  int                   crlf_seen;
  int                   abort_seen;
  logic [7:0]           err_code;
  int                   error_cnt;
  int                   checked;
  logic [31:0]          dummy;
  string                s;
  string                e;

  mpl_party_filter u_dut (
    .clk_i             (clk_i),
    .rst_i             (rst_i),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_byteenable_i  (avs_byteenable_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o),
    .rx_i              (rx),
    .hw_addr_i         (hw_addr_i),
    .cmd_o             (cmd_o),
    .err_o             (err_o),
    .crlf_o            (crlf_o),
    .party_active_o    (party_active_o)
  );

  mpl_host_model u_host (
    .clk_i (clk_i),
    .rx_o  (rx)
  );

  always #20 clk_i = ~clk_i;

  // Pulses last one cycle, so they are collected at every edge
  always @(posedge clk_i) begin
    if (cmd_o.valid === 1'b1) got_q.push_back({cmd_o.last, cmd_o.data});
    if (err_o.valid === 1'b1) begin
      err_seen++;
      err_code = err_o.code;
    end
    if (crlf_o === 1'b1) crlf_seen++;
    if (cmd_o.valid === 1'b1 && cmd_o.abort === 1'b1) abort_seen++;
  end

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= wd;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      $display("BAD %0t bus access timed out", $time);
      tally_and_finish();
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, dummy);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp,
                        input string msg);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    chk(v, exp, msg);
  endtask

  // Last flag is expected only on the final, terminating char
  task automatic line(input string str, input string exp, input int gap = 0);
    u_host.send_str(str, gap);
    chk(32'(got_q.size()), 32'(exp.len()), "forwarded count");
    for (int i = 0; i < exp.len() && i < got_q.size(); i++)
      chk(32'(got_q[i]), 32'({i == exp.len() - 1, exp[i]}), "forwarded char");
    got_q.delete();
  endtask

  initial begin
    clk_i            = 1'b0;
    rst_i            = 1'b1;
    avs_address_i    = 4'h0;
    avs_read_i       = 1'b0;
    avs_write_i      = 1'b0;
    avs_byteenable_i = 4'hF;
    avs_writedata_i  = 32'h0;
    hw_addr_i        = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk(4'h0, 32'h0, "ctrl reset");
    rd_chk(4'h4, 32'h21, "name reset");
    rd_chk(4'hC, 32'h0, "unmapped read");
    line("AB\r", "AB\r");
    wr_reg(4'h0, 32'h2);
    rd_chk(4'h0, 32'h2, "queued write");
    rd_chk(4'h8, 32'h0, "queued gated");
    line("^Z\r", "^Z\r");
    wr_reg(4'h0, 32'h1);
    chk(32'(party_active_o), 32'h0, "not yet active");
    line("!X\n", "");
    chk(32'(party_active_o), 32'h1, "active pin");
    rd_chk(4'h8, 32'h3, "party active");
    line("!P\n", "P\n");
    line("*Q\n", "Q\n", 3);
    line("^R\n", "");
    wr_reg(4'h0, 32'h3);
    rd_chk(4'h8, 32'h13, "queued effective");
    line("^R\n", "R\n");
    wr_reg(4'h4, 32'h41);
    // Lane 0 masked off, then an unmapped word: both must be ignored
    avs_byteenable_i <= 4'hE;
    wr_reg(4'h4, 32'h55);
    avs_byteenable_i <= 4'hF;
    wr_reg(4'hC, 32'h0);
    rd_chk(4'h4, 32'h41, "masked write");
    rd_chk(4'h0, 32'h3, "unmapped write");
    line("!S\n", "");
    line("AS\n", "S\n");
    line("*U\n", "U\n");
    line("#V\n", "");
    // Prefix counts towards the limit: 64 chars pass, the 65th overflows
    s = "A";
    e = "";
    for (int i = 0; i < 63; i++) begin
      s = {s, "a"};
      e = {e, "a"};
    end
    line({s, "\n"}, {e, "\n"});
    chk(32'(err_seen), 32'h0, "no error at limit");
    u_host.send_str({s, "a\n"}, 0);
    chk(32'(err_seen), 32'h1, "overflow error");
    chk(32'(err_code), 32'h14, "overflow code");
    chk(32'(crlf_seen), 32'h1, "overflow crlf");
    chk(32'(abort_seen), 32'h1, "overflow abort");
    got_q.delete();
    wr_reg(4'h0, 32'h0);
    // Party must drop for a cycle, else activation is never lost
    rd_chk(4'h8, 32'h0, "party off");
    hw_addr_i <= 4'h4;
    rd_chk(4'h8, 32'h5, "hw forced");
    line("\n", "");
    rd_chk(4'h8, 32'h7, "hw active");
    line("AT\n", "T\n");
    hw_addr_i <= 4'h0;
    tally_and_finish();
  end
endmodule

`default_nettype wire
